// ### common/swd_pkg.sv
/*
 * swd_pkg: constants, state enum and bus carriers for the supervisor
 * watchdog and chip-enable gating block.
 * Assumes one 20 MHz clock; analog comparators arrive as digital levels.
 */
package swd_pkg;

  // clock and internal oscillator rates
  localparam int unsigned SWD_CLK_HZ     = 20000000;
  localparam int unsigned SWD_OSC_HZ     = 6550;
  localparam int unsigned SWD_OSC_DIV_I  = SWD_CLK_HZ / SWD_OSC_HZ;
  localparam logic [11:0] SWD_OSC_DIV    = 12'(SWD_OSC_DIV_I);

  // internal oscillator periods in ms, then in oscillator ticks
  localparam int unsigned SWD_T_NORM_MS    = 100;
  localparam int unsigned SWD_T_LONG_MS    = 1600;
  localparam int unsigned SWD_T_RST_STD_MS = 50;
  localparam int unsigned SWD_T_RST_LNG_MS = 200;
  localparam logic [15:0] SWD_NORM_TICKS   =
    16'(SWD_T_NORM_MS * SWD_OSC_HZ / 1000);
  localparam logic [15:0] SWD_LONG_TICKS   =
    16'(SWD_T_LONG_MS * SWD_OSC_HZ / 1000);
  localparam logic [15:0] SWD_RST_STD_TICKS =
    16'(SWD_T_RST_STD_MS * SWD_OSC_HZ / 1000);
  localparam logic [15:0] SWD_RST_LNG_TICKS =
    16'(SWD_T_RST_LNG_MS * SWD_OSC_HZ / 1000);

  // external clock or capacitor mode, counted in timing-input cycles
  localparam logic [15:0] SWD_EXT_NORM    = 16'h0400;
  localparam logic [15:0] SWD_EXT_LONG    = 16'h1000;
  localparam logic [15:0] SWD_EXT_RST_STD = 16'h0200;
  localparam logic [15:0] SWD_EXT_RST_LNG = 16'h0800;

  // register map (byte addresses) and fields
  localparam logic [1:0]  SWD_IDX_CTRL   = 2'h0;
  localparam logic [1:0]  SWD_IDX_STATUS = 2'h1;
  localparam logic [1:0]  SWD_IDX_COUNT  = 2'h2;
  localparam logic [1:0]  SWD_IDX_NONE   = 2'h3;
  localparam logic [31:0] SWD_ADDR_CTRL   = 32'h0000_0000;
  localparam logic [31:0] SWD_ADDR_STATUS = 32'h0000_0004;
  localparam logic [31:0] SWD_ADDR_COUNT  = 32'h0000_0008;
  localparam int unsigned SWD_CTRL_LONG_BIT = 0;
  localparam logic        SWD_CTRL_LONG_RST = 1'b0;
  localparam logic [1:0]  SWD_HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    SWD_HOLD,
    SWD_PULSE,
    SWD_WATCH
  } swd_state_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } swd_ahb_req_t;

  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } swd_ahb_rsp_t;

  typedef struct packed {
    swd_state_t  st;
    logic [15:0] cnt;
    logic        post;
    logic        expired_n;
    logic        rst_n;
    logic        pf_flag_n;
    logic        ce_n;
    logic        kick_smp;
    logic        tin_d;
    logic [11:0] div;
    logic        long_dly;
    logic        bus_wr;
    logic [1:0]  bus_idx;
    logic [31:0] rdata;
  } swd_regs_t;

endpackage : swd_pkg

// ### core/swd_supervisor.sv
/*
 * swd_supervisor: chip-enable gating, power-fail flag and watchdog with
 * reset pulse generation, plus an AHB-Lite register slave.
 * Assumes all inputs synchronous to mclk; comparators and "floating"
 * pin states are supplied as digital levels.
 */
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
// Summary of operation
// - valid supply passes chip-enable straight through
// - below reset threshold forces chip-enable high
// - below battery also forces chip-enable high
// - power-fail flag low while input below reference
// - battery backup ignores power-fail comparator
// - missed kick yields reset pulse of set width
// - post-reset long timeout until first kick
// - watchdog counter restarts at reset pulse end
// - stuck kick repeats resets at long interval
// - floating kick disables watchdog supervision
// - expired flag low until next kick transition
// - expired flag high when supply below threshold
// - internal oscillator, timing input picks timeout
// - external clock mode counts timing-input cycles
// - external mode reset width per variant
// - internal mode reset width per variant
// - capacitor mode scales with oscillator frequency
// - internal oscillator at fixed nominal rate
module swd_supervisor
  import swd_pkg::*;
#(
  parameter logic [11:0] OSC_DIV        = SWD_OSC_DIV,
  parameter logic [15:0] WDT_LONG_TICKS = SWD_LONG_TICKS
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic         supply_below_reset,
  input  wire logic         supply_below_batt,
  input  wire logic         pf_below_ref,
  input  wire logic         ce_in_n,
  input  wire logic         watchdog_kick_input,
  input  wire logic         kick_floating,
  input  wire logic         oscillator_source_select,
  input  wire logic         oscillator_source_select_floating,
  input  wire logic         oscillator_timing_input,
  input  wire logic         oscillator_timing_input_floating,
  input  wire swd_ahb_req_t ahb_req,
  output swd_ahb_rsp_t      ahb_rsp,
  output logic              ce_out_n,
  output logic              power_fail_flag_n,
  output logic              watchdog_expired_n,
  output logic              reset_out_n
);

  if (OSC_DIV < 12'h002) begin : g_bad_div
    $error("swd_supervisor: OSC_DIV must be at least 2");
  end
  if (WDT_LONG_TICKS < 16'h0002) begin : g_bad_long
    $error("swd_supervisor: WDT_LONG_TICKS must be at least 2");
  end

  swd_regs_t r_r;
  swd_regs_t r_nxt;

  logic        ext_mode;
  logic        supply_bad;
  logic        tick;
  logic        kick_tr;
  logic        expire;
  logic        pulse_done;
  logic [15:0] tmo;
  logic [15:0] width;
  logic [1:0]  addr_idx;
  logic        bus_take;
  logic [31:0] status;

  // external timing only when the select pin is driven low
  function automatic logic ext_sel(
    input logic sel,
    input logic sel_float
  );
    ext_sel = (sel == 1'b0) && !sel_float;
  endfunction : ext_sel

  // terminal count test, shared by watch and pulse phases
  function automatic logic at_end(
    input logic [15:0] cnt,
    input logic [15:0] lim
  );
    at_end = (cnt >= lim - 16'h0001);
  endfunction : at_end

  function automatic logic [15:0] pick_tmo(
    input logic        post,
    input logic        ext,
    input logic        in_float,
    input logic [15:0] long_ticks
  );
    if (post) begin
      pick_tmo = ext ? SWD_EXT_LONG : long_ticks;
    end else if (ext) begin
      pick_tmo = SWD_EXT_NORM;
    end else if (in_float) begin
      pick_tmo = long_ticks;
    end else begin
      pick_tmo = SWD_NORM_TICKS;
    end
  endfunction : pick_tmo

  // reset width per mode and variant
  function automatic logic [15:0] pick_width(
    input logic ext,
    input logic long_dly
  );
    if (ext) begin
      pick_width = long_dly ? SWD_EXT_RST_LNG : SWD_EXT_RST_STD;
    end else begin
      pick_width = long_dly ? SWD_RST_LNG_TICKS : SWD_RST_STD_TICKS;
    end
  endfunction : pick_width

  // word-aligned decode; anything else reads as unmapped
  function automatic logic [1:0] decode_idx(
    input logic [31:0] addr
  );
    if ((addr[31:4] == 28'h0000000) && (addr[1:0] == 2'h0)) begin
      decode_idx = addr[3:2];
    end else begin
      decode_idx = SWD_IDX_NONE;
    end
  endfunction : decode_idx

  // status word, bit order fixed for software
  function automatic logic [31:0] pack_status(
    input logic ext,
    input logic ce_n,
    input logic pf_n,
    input logic post,
    input logic exp_n,
    input logic rst_n
  );
    pack_status      = 32'h0000_0000;
    pack_status[5:0] = {ext, ce_n, pf_n, post, exp_n, rst_n};
  endfunction : pack_status

  // read mux; unmapped words read zero
  function automatic logic [31:0] read_mux(
    input logic [1:0]  idx,
    input logic        long_dly,
    input logic [31:0] stat,
    input logic [15:0] cnt
  );
    read_mux = 32'h0000_0000;
    case (idx)
      SWD_IDX_CTRL: begin
        read_mux[0] = long_dly;
      end
      SWD_IDX_STATUS: begin
        read_mux = stat;
      end
      SWD_IDX_COUNT: begin
        read_mux[15:0] = cnt;
      end
      default: begin
        read_mux = 32'h0000_0000;
      end
    endcase
  endfunction : read_mux

  // power-up image: reset pulse pending, flags idle high
  function automatic swd_regs_t reset_regs();
    swd_regs_t v;
    v           = '0;
    v.st        = SWD_HOLD;
    v.cnt       = 16'h0000;
    v.post      = 1'b1;
    v.expired_n = 1'b1;
    v.rst_n     = 1'b0;
    v.pf_flag_n = 1'b1;
    v.ce_n      = 1'b1;
    v.kick_smp  = 1'b0;
    v.tin_d     = 1'b0;
    v.div       = 12'h000;
    v.long_dly  = SWD_CTRL_LONG_RST;
    v.bus_wr    = 1'b0;
    v.bus_idx   = SWD_IDX_NONE;
    v.rdata     = 32'h0000_0000;
    reset_regs  = v;
  endfunction : reset_regs

  always_comb begin
    r_nxt      = r_r;
    ext_mode   = ext_sel(oscillator_source_select, oscillator_source_select_floating);
    supply_bad = supply_below_reset || supply_below_batt;

    tick        = 1'b0;
    r_nxt.tin_d = oscillator_timing_input;
    if (ext_mode) begin
      tick      = oscillator_timing_input && !r_r.tin_d;
      r_nxt.div = 12'h000;
    end else if (r_r.div >= OSC_DIV - 12'h001) begin
      tick      = 1'b1;
      r_nxt.div = 12'h000;
    end else begin
      r_nxt.div = r_r.div + 12'h001;
    end

    // kick resampled per tick, either edge
    // slow sampling filters glitches shorter than a tick
    kick_tr = tick && (watchdog_kick_input != r_r.kick_smp);
    if (tick) begin
      r_nxt.kick_smp = watchdog_kick_input;
    end

    tmo        = pick_tmo(r_r.post, ext_mode, oscillator_timing_input_floating,
                          WDT_LONG_TICKS);
    width      = pick_width(ext_mode, r_r.long_dly);
    expire     = tick && at_end(r_r.cnt, tmo);
    pulse_done = tick && at_end(r_r.cnt, width);

    // any kick edge clears the expired flag
    if (kick_tr) begin
      r_nxt.expired_n = 1'b1;
    end

    case (r_r.st)
      SWD_HOLD: begin
        // one cycle here, then the pulse is timed
        r_nxt.st  = SWD_PULSE;
        r_nxt.cnt = 16'h0000;
      end
      SWD_PULSE: begin
        if (pulse_done) begin
          r_nxt.st   = SWD_WATCH;
          r_nxt.cnt  = 16'h0000;
          r_nxt.post = 1'b1;
        end else if (tick) begin
          r_nxt.cnt = r_r.cnt + 16'h0001;
        end
      end
      SWD_WATCH: begin
        if (kick_floating) begin
          r_nxt.cnt = 16'h0000;
        end else if (kick_tr) begin
          r_nxt.cnt  = 16'h0000;
          r_nxt.post = 1'b0;
        end else if (expire) begin
          r_nxt.st        = SWD_PULSE;
          r_nxt.cnt       = 16'h0000;
          r_nxt.expired_n = 1'b0;
          r_nxt.post      = 1'b1;
        end else if (tick) begin
          r_nxt.cnt = r_r.cnt + 16'h0001;
        end
      end
      default: begin
        r_nxt.st = SWD_HOLD;
      end
    endcase

    // low supply holds reset, clears expiry
    // battery backup also holds reset, as in a power loss
    if (supply_bad) begin
      r_nxt.st        = SWD_HOLD;
      r_nxt.cnt       = 16'h0000;
      r_nxt.post      = 1'b1;
      r_nxt.expired_n = 1'b1;
    end
    r_nxt.rst_n = (r_nxt.st == SWD_WATCH);

    // registered copy gives the delay
    // one mclk of lag, well inside a ram cycle at this rate
    r_nxt.ce_n = ce_in_n || supply_bad;

    r_nxt.pf_flag_n = supply_below_batt ? 1'b0 : !pf_below_ref;

    // bus: decode address phase, write lands in data phase
    status   = pack_status(ext_mode, r_r.ce_n, r_r.pf_flag_n,
                           r_r.post, r_r.expired_n, r_r.rst_n);
    addr_idx = decode_idx(ahb_req.haddr);
    bus_take = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
    if (r_r.bus_wr && (r_r.bus_idx == SWD_IDX_CTRL)) begin
      r_nxt.long_dly = ahb_req.hwdata[SWD_CTRL_LONG_BIT];
    end
    r_nxt.bus_wr = 1'b0;
    if (bus_take) begin
      r_nxt.bus_wr  = ahb_req.hwrite;
      r_nxt.bus_idx = addr_idx;
      r_nxt.rdata   = 32'h0000_0000;
      if (!ahb_req.hwrite) begin
        // data registered at the address edge, stands in data phase
        r_nxt.rdata = read_mux(addr_idx, r_r.long_dly, status, r_r.cnt);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r_r <= reset_regs();
    end else begin
      r_r <= r_nxt;
    end
  end

  // zero-wait slave, always OKAY
  assign ahb_rsp.hreadyout = 1'b1;
  assign ahb_rsp.hresp     = 1'b0;
  assign ahb_rsp.hrdata    = r_r.rdata;

  // all pin outputs straight from flip-flops
  assign ce_out_n           = r_r.ce_n;
  assign power_fail_flag_n  = r_r.pf_flag_n;
  assign watchdog_expired_n = r_r.expired_n;
  assign reset_out_n        = r_r.rst_n;

endmodule : swd_supervisor

// ### tb/swd_chk.sv
/* swd_chk: assertions on the swd_supervisor ports.
   Bound from the bench top; one clock, synchronous reset. */
`timescale 1ns/100ps
module swd_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic supply_below_reset,
  input wire logic supply_below_batt,
  input wire logic pf_below_ref,
  input wire logic ce_in_n,
  input wire logic kick_floating,
  input wire logic ce_out_n,
  input wire logic power_fail_flag_n,
  input wire logic watchdog_expired_n,
  input wire logic reset_out_n
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  ce_copy_a: assert property (
    !sys_rst && !supply_below_reset && !supply_below_batt
    |=> ce_out_n == $past(ce_in_n)) else $error("ce not copied");
  ce_low_a: assert property (
    supply_below_reset |=> ce_out_n) else $error("ce not gated");
  ce_batt_a: assert property (
    supply_below_batt |=> ce_out_n) else $error("ce on in backup");
  pf_flag_a: assert property (
    !sys_rst && !supply_below_batt
    |=> power_fail_flag_n == !$past(pf_below_ref)) else $error("pf flag");
  pf_off_a: assert property (
    !sys_rst && supply_below_batt |=> !power_fail_flag_n)
    else $error("pf flag in backup");
  expired_high_a: assert property (
    supply_below_reset |=> watchdog_expired_n) else $error("wdo low");
  expiry_a: assert property (
    $fell(watchdog_expired_n) |-> $fell(reset_out_n))
    else $error("expiry without reset");
  float_a: assert property (
    kick_floating [*3] |=> !$fell(watchdog_expired_n))
    else $error("expiry while off");
endmodule : swd_chk

// ### tb/swd_cpu_model.sv
/* swd_cpu_model: processor side, flips the kick line on request.
   Assumes kick_req is a one-cycle pulse. */
`timescale 1ns/100ps
module swd_cpu_model (
  input  wire logic mclk,
  input  wire logic reset_out_n,
  input  wire logic kick_req,
  output logic      kick = 1'b0
);
  // hold in reset; a flip here would clear the expired flag
  always @(posedge mclk) begin
    if (kick_req && reset_out_n) begin
      kick <= ~kick;
    end
  end
endmodule : swd_cpu_model

// ### tb/supervisor_watchdog_ce_gating_tb_top.sv
/* Bench top: swd_supervisor with cpu model and bound checker.
   Assumes package, design, checker and model compile first. */
`timescale 1ns/100ps
module supervisor_watchdog_ce_gating_tb_top import swd_pkg::*; ();
  // small divider and post-reset count keep the run short
  localparam logic [11:0] DIV  = 12'h004;
  localparam logic [15:0] LONG = 16'h0028;
  logic         mclk = 1'b0, sys_rst = 1'b1, ext = 1'b0, kick_req = 1'b0;
  logic         supply_below_reset = 1'b0, supply_below_batt = 1'b0;
  logic         pf_below_ref = 1'b0, ce_in_n = 1'b1, kick_floating = 1'b0;
  logic         oscillator_timing_input_float = 1'b0;
  logic         watchdog_kick_input, ce_out_n, power_fail_flag_n;
  logic         watchdog_expired_n, reset_out_n;
  logic [31:0]  r;
  int           c, errors = 0, checks_done = 0, cyc = 0;
  swd_ahb_req_t rq = '0;
  swd_ahb_rsp_t ahb_rsp;
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      summarize();
    end
  end
  swd_supervisor #(.OSC_DIV(DIV), .WDT_LONG_TICKS(LONG)) u_swd_supervisor (
    .mclk, .sys_rst, .supply_below_reset, .supply_below_batt,
    .pf_below_ref, .ce_in_n, .watchdog_kick_input, .kick_floating,
    .oscillator_source_select(1'b0), .oscillator_source_select_floating(!ext),
    .oscillator_timing_input(cyc[1] & ext), .oscillator_timing_input_floating(oscillator_timing_input_float),
    .ahb_req({rq[71:1], ahb_rsp.hreadyout}), .ahb_rsp, .ce_out_n,
    .power_fail_flag_n, .watchdog_expired_n, .reset_out_n);
  swd_cpu_model u_swd_cpu_model (.mclk, .reset_out_n, .kick_req,
    .kick(watchdog_kick_input));
  task automatic chk(string n, logic [31:0] e, g, tol);
    checks_done++;
    if (tol == 0 ? g !== e : g > e + tol || g + tol < e) begin
      errors++;
      $display("unexpected %s expected %0d seen %0d", n, e, g);
    end
  endtask : chk
  task automatic summarize;
    $display("checks_done %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task automatic ahb(logic w, logic [31:0] a, d);
    @(posedge mclk);
    rq <= '{1'b1, a, SWD_HTRANS_NONSEQ, w, 3'h2, 32'h0, 1'b0};
    do @(posedge mclk); while (ahb_rsp.hreadyout !== 1'b1);
    rq <= '{1'b0, a, 2'h0, w, 3'h2, d, 1'b0};
    do @(posedge mclk); while (ahb_rsp.hreadyout !== 1'b1);
    r = ahb_rsp.hrdata;
  endtask : ahb
  task automatic meas(logic lv, int lim);
    c = 0;
    @(negedge mclk);
    while (reset_out_n === lv && c < lim) begin
      c++;
      @(negedge mclk);
    end
  endtask : meas
  task automatic poke;
    @(posedge mclk);
    kick_req <= 1'b1;
    @(posedge mclk);
    kick_req <= 1'b0;
  endtask : poke
  task automatic t_bus;
    ahb(1'b1, SWD_ADDR_CTRL, 32'h1);
    ahb(1'b0, SWD_ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h1, r, 0);
    ahb(1'b0, 32'hC, 32'h0);
    chk("unmapped", 32'h0, r, 0);
    ahb(1'b0, SWD_ADDR_STATUS, 32'h0);
    chk("status", 32'h1E, r, 0);
    chk("hresp", 32'h0, ahb_rsp.hresp, 0);
    ahb(1'b1, SWD_ADDR_CTRL, 32'h0);
    $display("bus test done");
  endtask : t_bus
  task automatic t_pins;
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      {supply_below_reset, supply_below_batt, ce_in_n, pf_below_ref} <= 4'(i);
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk("ce_out_n", i[3] | i[2] | i[1], ce_out_n, 0);
      chk("pfo_n", !i[2] & !i[0], power_fail_flag_n, 0);
      if (i[3]) chk("wdo_n", 1, watchdog_expired_n, 0);
    end
    @(posedge mclk);
    {supply_below_reset, supply_below_batt} <= 2'h0;
    $display("pin test done");
  endtask : t_pins
  task automatic t_wdt;
    meas(1'b0, 20000);
    chk("reset width", 4 * SWD_RST_STD_TICKS, c, 12);
    meas(1'b1, 20000);
    chk("post timeout", 4 * LONG, c, 12);
    chk("wdo_n", 0, watchdog_expired_n, 0);
    meas(1'b0, 20000);
    chk("wdo_n held", 0, watchdog_expired_n, 0);
    poke();
    repeat (32) @(negedge mclk);
    chk("wdo_n", 1, watchdog_expired_n, 0);
    meas(1'b1, 20000);
    chk("normal timeout", 4 * SWD_NORM_TICKS, c + 34, 12);
    @(posedge mclk);
    oscillator_timing_input_float <= 1'b1;
    meas(1'b0, 20000);
    poke();
    repeat (8) @(negedge mclk);
    meas(1'b1, 20000);
    chk("long normal timeout", 4 * LONG, c + 10, 12);
    @(posedge mclk);
    kick_floating <= 1'b1;
    meas(1'b0, 20000);
    meas(1'b1, 1000);
    chk("no expiry", 1000, c, 0);
    $display("watchdog test done");
  endtask : t_wdt
  task automatic t_ext;
    ahb(1'b1, SWD_ADDR_CTRL, 32'h1);
    ext <= 1'b1;
    supply_below_reset <= 1'b1;
    repeat (4) @(posedge mclk);
    supply_below_reset <= 1'b0;
    meas(1'b0, 20000);
    chk("ext reset width", 4 * SWD_EXT_RST_LNG, c, 12);
    $display("external clock test done");
  endtask : t_ext
  initial begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    t_bus();
    t_pins();
    t_wdt();
    t_ext();
    summarize();
  end
endmodule : supervisor_watchdog_ce_gating_tb_top
bind swd_supervisor swd_chk u_swd_chk (.mclk, .sys_rst, .supply_below_reset,
  .supply_below_batt, .pf_below_ref, .ce_in_n, .kick_floating, .ce_out_n,
  .power_fail_flag_n, .watchdog_expired_n, .reset_out_n);
